// ==== verilog/pvic_pkg.sv ====
// constants and register map of the prioritized vector interrupt controller
package pvic_pkg;
    localparam int NUM_SRC = 44;
    localparam int NUM_POS = 48;
    localparam int NUM_TRAPS = 4;
    localparam int NUM_CAND = NUM_TRAPS + NUM_POS;
    localparam int LVL_W = 4;
    localparam int VEC_W = 6;
    localparam int PC_W = 24;
    localparam int ADDR_W = 8;
    localparam int TIMED_INTERRUPT_BLOCK_W = 14;
    localparam logic [NUM_POS-1:0] IMPL_MASK = 48'h1dffffffffff;
    localparam logic [VEC_W-1:0] SRC_VEC_OFFSET = 6'h08;
    localparam logic [VEC_W-1:0] TRAP_VEC_FIRST = 6'h01;
    localparam logic [NUM_TRAPS*LVL_W-1:0] TRAP_LEVELS = 16'hedcb;
    localparam int TRAP_ADDR_ERR = 1;
    localparam logic [PC_W-1:0] PRIMARY_BASE = 24'h000004;
    localparam logic [PC_W-1:0] ALT_BASE = 24'h000084;
    localparam logic [PC_W-1:0] VEC_SPACE_END = 24'h0000fe;
    localparam logic [2:0] TIMED_INTERRUPT_BLOCK_CEILING = 3'h6;
    localparam int BIT_NEST_DIS = 15;
    localparam int BIT_ALT_TABLE = 15;
    localparam int BIT_TIMED_INTERRUPT_BLOCK_ACTIVE = 14;
    localparam int EXT_EDGE_W = 5;
    localparam logic [5:0] IDX_FLAG0 = 6'h00;
    localparam logic [5:0] IDX_EN0 = 6'h03;
    localparam logic [5:0] IDX_PRIO0 = 6'h08;
    localparam logic [5:0] IDX_CTRL1 = 6'h14;
    localparam logic [5:0] IDX_CTRL2 = 6'h15;
    localparam logic [5:0] IDX_CPU_LVL = 6'h16;
    localparam logic [5:0] IDX_TIMED_INTERRUPT_BLOCK = 6'h17;
    localparam logic [5:0] IDX_STATUS = 6'h18;
    localparam int NUM_FLAG_REGS = 3;
    localparam int NUM_PRIO_REGS = 12;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [LVL_W-1:0] RESET_CPU_LVL = 4'h0;
    typedef enum logic [1:0] {
        PVIC_IDLE,
        PVIC_REQ,
        PVIC_FETCH,
        PVIC_LOAD
    } pvic_state_type;
endpackage

// ==== verilog/pvic_arbiter.sv ====
// level-then-natural-order arbiter
`timescale 1ns/1ps
module pvic_arbiter
    import pvic_pkg::*;
#(
    parameter int N = 52,
    parameter int LW = 4,
    parameter int IW = 6
)
(
    input wire logic [N-1:0] cand_valid,
    input wire logic [N*LW-1:0] cand_level,
    output logic win_valid,
    output logic [IW-1:0] win_index,
    output logic [LW-1:0] win_level
);
    // descending scan with >= so the lowest index wins a tie
    always_comb
    begin
        win_valid = 1'b0;
        win_index = '0;
        win_level = '0;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (cand_valid[i] && (!win_valid || cand_level[i*LW +: LW] >= win_level))
            begin
                win_valid = 1'b1;
                win_index = IW'(i);
                win_level = cand_level[i*LW +: LW];
            end
        end
    end
endmodule // pvic_arbiter

// ==== verilog/pvic_top.sv ====
// interrupt controller top: registers, arbitration and vector fetch
`timescale 1ns/1ps
// What this block does
// - arbitrate 44 sources plus four exceptions
// - vector word muxed 24 bits into pc
// - vector tables start at words 0x000004 and 0x000084
// - three flag registers, hardware sets, software clears
// - three enable registers gate each source
// - twelve priority registers, last uses only its low nibble
// - cpu priority is four bits, split
// - flags set regardless of enable bit
// - priorities 1 to 7, seven highest
// - priority zero never serviced
// - nesting disable blocks interrupts during service
// - cpu priority read-only while nesting disabled
// - timed block masks levels six and below
// - 63 vectors, 0x000004 to 0x0000fe
// - vector space fetch or jump traps
// - 3-bit field per nibble, bit three zero
// - equal priority picks lowest source number
// - vector is source number plus eight
// - control two: external edges, alternate table
// - control one: exception flags and controls
// - trigger style lives in peripheral
// - sample flags at instruction cycle start
// - interrupt only above current cpu priority
// - accept stacks old level, loads new
// - traps use levels 11 to 14
module pvic_top
    import pvic_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NUM_SRC-1:0] src_req,
    input wire logic [NUM_TRAPS-1:0] trap_req,
    input wire logic fetch_valid,
    input wire logic [PC_W-1:0] fetch_addr,
    input wire logic jump_valid,
    input wire logic [PC_W-1:0] jump_target,
    input wire logic instr_start,
    input wire logic core_ack,
    input wire logic return_valid,
    input wire logic [LVL_W-1:0] return_level,
    input wire logic prog_data_valid,
    input wire logic [PC_W-1:0] prog_data,
    output logic irq_request,
    output logic [VEC_W-1:0] irq_vector,
    output logic [LVL_W-1:0] irq_level,
    output logic vec_fetch_req,
    output logic [PC_W-1:0] vec_fetch_addr,
    output logic pc_load,
    output logic [PC_W-1:0] pc_load_value,
    output logic [LVL_W-1:0] saved_level,
    output logic [LVL_W-1:0] cpu_priority_level,
    output logic [EXT_EDGE_W-1:0] ext_edge_select
);
    logic [NUM_POS-1:0] flags;
    logic [NUM_POS-1:0] enables;
    logic [2:0] prio [NUM_POS];
    logic [NUM_TRAPS-1:0] trap_flags;
    logic nest_dis;
    logic alt_table;
    logic [TIMED_INTERRUPT_BLOCK_W-1:0] timed_interrupt_block_count;
    logic [5:0] depth;
    logic [NUM_POS-1:0] snap_src;
    logic [NUM_TRAPS-1:0] snap_trap;
    logic eval;
    pvic_state_type state;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic aw_got;
    logic w_got;
    logic wr_fire;
    logic [5:0] wr_idx;
    logic [15:0] wmask;
    logic [15:0] wd;
    logic [31:0] rd_word;
    logic rd_ok;
    logic [NUM_POS-1:0] src_pos;
    logic [NUM_POS-1:0] next_flags;
    logic [NUM_TRAPS-1:0] next_trap_flags;
    logic vec_space_hit;
    logic timed_interrupt_block_active;
    logic service_block;
    logic [NUM_CAND-1:0] cand_valid;
    logic [NUM_CAND*LVL_W-1:0] cand_level;
    logic win_valid;
    logic [VEC_W-1:0] win_index;
    logic [LVL_W-1:0] win_level;
    logic [VEC_W-1:0] win_vector;

    // ----------------------------------------
    // bus slave handshake
    // ----------------------------------------
    assign wr_fire = aw_got && w_got && !s_axi_bvalid;
    assign wr_idx = wr_addr[7:2];
    assign wmask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
    assign wd = wr_data[15:0];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            wr_addr <= '0;
            wr_data <= '0;
            wr_strb <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got <= 1'b1;
                wr_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got <= 1'b1;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_idx <= IDX_TIMED_INTERRUPT_BLOCK) ? RESP_OKAY : RESP_SLVERR;
                aw_got <= 1'b0;
                w_got <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // read decode; reserved bits and unused nibble bits read zero
    always_comb
    begin
        rd_word = '0;
        rd_ok = 1'b1;
        case (s_axi_araddr[7:2])
            IDX_FLAG0, IDX_FLAG0 + 6'h1, IDX_FLAG0 + 6'h2:
                rd_word[15:0] = flags[16*(s_axi_araddr[3:2] - IDX_FLAG0[1:0]) +: 16];
            IDX_EN0, IDX_EN0 + 6'h1, IDX_EN0 + 6'h2:
                rd_word[15:0] = enables[16*(s_axi_araddr[7:2] - IDX_EN0) +: 16];
            IDX_CTRL1:
                rd_word[15:0] = {nest_dis, 11'h000, trap_flags};
            IDX_CTRL2:
                rd_word[15:0] = {alt_table, timed_interrupt_block_active, 9'h000, ext_edge_select};
            IDX_CPU_LVL:
                rd_word[LVL_W-1:0] = cpu_priority_level;
            IDX_TIMED_INTERRUPT_BLOCK:
                rd_word[TIMED_INTERRUPT_BLOCK_W-1:0] = timed_interrupt_block_count;
            IDX_STATUS:
                rd_word[15:0] = {state, depth, 2'h0, irq_vector};
            default:
            begin
                if (s_axi_araddr[7:2] >= IDX_PRIO0 && s_axi_araddr[7:2] < IDX_PRIO0 + 6'(NUM_PRIO_REGS))
                begin
                    for (int j = 0; j < 4; j++)
                        rd_word[4*j +: 3] = prio[4*(s_axi_araddr[7:2] - IDX_PRIO0) + j];
                end
                else
                    rd_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
                s_axi_rvalid <= 1'b1;
                s_axi_arready <= 1'b0;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // request flags and trap flags
    // ----------------------------------------
    // spread the 44 request inputs onto implemented positions only
    always_comb
    begin
        int k;
        k = 0;
        src_pos = '0;
        for (int p = 0; p < NUM_POS; p++)
        begin
            if (IMPL_MASK[p])
            begin
                src_pos[p] = src_req[k];
                k = k + 1;
            end
        end
    end

    assign vec_space_hit = (fetch_valid && fetch_addr >= PRIMARY_BASE && fetch_addr <= VEC_SPACE_END)
        || (jump_valid && jump_target >= PRIMARY_BASE && jump_target <= VEC_SPACE_END);

    always_comb
    begin
        next_flags = flags;
        next_trap_flags = trap_flags;
        if (wr_fire)
        begin
            for (int r = 0; r < NUM_FLAG_REGS; r++)
                if (wr_idx == IDX_FLAG0 + 6'(r))
                    next_flags[16*r +: 16] = (flags[16*r +: 16] & ~wmask) | (wd & wmask);
            if (wr_idx == IDX_CTRL1)
                next_trap_flags = (trap_flags & ~wmask[NUM_TRAPS-1:0]) | (wd[NUM_TRAPS-1:0] & wmask[NUM_TRAPS-1:0]);
        end
        next_flags = (next_flags | src_pos) & IMPL_MASK;
        next_trap_flags = next_trap_flags | trap_req;
        next_trap_flags[TRAP_ADDR_ERR] = next_trap_flags[TRAP_ADDR_ERR] | vec_space_hit;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            flags <= '0;
            trap_flags <= '0;
        end
        else if (ce)
        begin
            flags <= next_flags;
            trap_flags <= next_trap_flags;
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            enables <= '0;
            nest_dis <= 1'b0;
            alt_table <= 1'b0;
            ext_edge_select <= '0;
            for (int p = 0; p < NUM_POS; p++)
                prio[p] <= '0;
        end
        else if (ce && wr_fire)
        begin
            for (int r = 0; r < NUM_FLAG_REGS; r++)
                if (wr_idx == IDX_EN0 + 6'(r))
                    enables[16*r +: 16] <= ((enables[16*r +: 16] & ~wmask) | (wd & wmask))
                        & IMPL_MASK[16*r +: 16];
            for (int r = 0; r < NUM_PRIO_REGS; r++)
                for (int j = 0; j < 4; j++)
                    if (wr_idx == IDX_PRIO0 + 6'(r) && wr_strb[j/2] && IMPL_MASK[4*r+j])
                        prio[4*r+j] <= wd[4*j +: 3];
            if (wr_idx == IDX_CTRL1 && wr_strb[1])
                nest_dis <= wd[BIT_NEST_DIS];
            if (wr_idx == IDX_CTRL2 && wr_strb[1])
                alt_table <= wd[BIT_ALT_TABLE];
            if (wr_idx == IDX_CTRL2 && wr_strb[0])
                ext_edge_select <= wd[EXT_EDGE_W-1:0];
        end
    end

    // timed block counts down one per instruction cycle
    assign timed_interrupt_block_active = timed_interrupt_block_count != '0;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            timed_interrupt_block_count <= '0;
        else if (ce)
        begin
            if (wr_fire && wr_idx == IDX_TIMED_INTERRUPT_BLOCK)
                timed_interrupt_block_count <= wd[TIMED_INTERRUPT_BLOCK_W-1:0];
            else if (instr_start && timed_interrupt_block_active)
                timed_interrupt_block_count <= timed_interrupt_block_count - 1'b1;
        end
    end

    // ----------------------------------------
    // cpu priority level and service depth
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cpu_priority_level <= RESET_CPU_LVL;
            saved_level <= '0;
            depth <= '0;
        end
        else if (ce)
        begin
            if (state == PVIC_REQ && core_ack)
            begin
                saved_level <= cpu_priority_level;
                cpu_priority_level <= irq_level;
                depth <= depth + 1'b1;
            end
            else if (return_valid)
            begin
                cpu_priority_level <= return_level;
                depth <= (depth != '0) ? depth - 1'b1 : depth;
            end
            else if (wr_fire && wr_idx == IDX_CPU_LVL && wr_strb[0] && !nest_dis)
                cpu_priority_level[2:0] <= wd[2:0];
        end
    end

    // ----------------------------------------
    // sampling and arbitration
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            snap_src <= '0;
            snap_trap <= '0;
            eval <= 1'b0;
        end
        else if (ce)
        begin
            eval <= instr_start;
            if (instr_start)
            begin
                snap_src <= flags & enables & IMPL_MASK;
                snap_trap <= trap_flags;
            end
        end
    end

    assign service_block = nest_dis && depth != '0;

    always_comb
    begin
        for (int t = 0; t < NUM_TRAPS; t++)
        begin
            cand_level[t*LVL_W +: LVL_W] = TRAP_LEVELS[t*LVL_W +: LVL_W];
            cand_valid[t] = snap_trap[t] && TRAP_LEVELS[t*LVL_W +: LVL_W] > cpu_priority_level;
        end
        for (int p = 0; p < NUM_POS; p++)
        begin
            cand_level[(NUM_TRAPS+p)*LVL_W +: LVL_W] = {1'b0, prio[p]};
            cand_valid[NUM_TRAPS+p] = snap_src[p] && IMPL_MASK[p]
                && prio[p] != 3'h0
                && {1'b0, prio[p]} > cpu_priority_level
                && !service_block
                && !(timed_interrupt_block_active && prio[p] <= TIMED_INTERRUPT_BLOCK_CEILING);
        end
    end

    pvic_arbiter #(
        .N(NUM_CAND),
        .LW(LVL_W),
        .IW(VEC_W)
    ) u_arbiter (
        .cand_valid(cand_valid),
        .cand_level(cand_level),
        .win_valid(win_valid),
        .win_index(win_index),
        .win_level(win_level)
    );

    assign win_vector = (win_index < 6'(NUM_TRAPS)) ? TRAP_VEC_FIRST + win_index
        : win_index - 6'(NUM_TRAPS) + SRC_VEC_OFFSET;

    // ----------------------------------------
    // request, vector fetch and pc load
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= PVIC_IDLE;
            irq_request <= 1'b0;
            irq_vector <= '0;
            irq_level <= '0;
            vec_fetch_req <= 1'b0;
            vec_fetch_addr <= '0;
            pc_load <= 1'b0;
            pc_load_value <= '0;
        end
        else if (ce)
        begin
            case (state)
                PVIC_IDLE:
                begin
                    pc_load <= 1'b0;
                    if (eval && win_valid)
                    begin
                        irq_request <= 1'b1;
                        irq_vector <= win_vector;
                        irq_level <= win_level;
                        state <= PVIC_REQ;
                    end
                end
                PVIC_REQ:
                begin
                    if (core_ack)
                    begin
                        irq_request <= 1'b0;
                        vec_fetch_req <= 1'b1;
                        vec_fetch_addr <= (alt_table ? ALT_BASE : PRIMARY_BASE)
                            + {17'h00000, irq_vector, 1'b0};
                        state <= PVIC_FETCH;
                    end
                end
                PVIC_FETCH:
                begin
                    if (prog_data_valid)
                    begin
                        vec_fetch_req <= 1'b0;
                        pc_load_value <= prog_data;
                        pc_load <= 1'b1;
                        state <= PVIC_LOAD;
                    end
                end
                PVIC_LOAD:
                begin
                    pc_load <= 1'b0;
                    state <= PVIC_IDLE;
                end
                default:
                    state <= PVIC_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence fetch_then_load_s;
        vec_fetch_req && prog_data_valid && ce ##1 pc_load;
    endsequence

    zero_prio_never_a: assert property (@(posedge aclk) disable iff (!aresetn)
        eval && win_valid && win_index >= 6'(NUM_TRAPS) |-> cand_level[win_index*LVL_W +: LVL_W] != 4'h0)
        else $error("zero priority source won");
    above_cpu_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(irq_request) |-> irq_level > $past(cpu_priority_level))
        else $error("request not above cpu level");
    nest_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(irq_request) && irq_level < 4'h8 |-> !$past(service_block))
        else $error("nested interrupt while disabled");
    cpu_lvl_ro_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && nest_dis && !(state == PVIC_REQ && core_ack) && !return_valid
        |=> $stable(cpu_priority_level))
        else $error("cpu level written while read-only");
    vector_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
        eval && win_valid && win_index >= 6'(NUM_TRAPS) |-> win_vector == win_index + 6'h04)
        else $error("vector not source plus eight");
    pc_mux_a: assert property (@(posedge aclk) disable iff (!aresetn)
        fetch_then_load_s |-> pc_load_value == $past(prog_data))
        else $error("pc load value not vector word");
    fetch_addr_a: assert property (@(posedge aclk) disable iff (!aresetn)
        vec_fetch_req |-> vec_fetch_addr >= PRIMARY_BASE && vec_fetch_addr <= VEC_SPACE_END)
        else $error("vector fetch outside table");
    flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && src_req[0] |=> flags[0])
        else $error("request flag not set");
    timed_interrupt_block_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(irq_request) && $past(timed_interrupt_block_active) |-> irq_level > 4'h6)
        else $error("low level taken during timed block");
    reserved_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (flags & ~IMPL_MASK) == '0)
        else $error("reserved flag set");
    accept_lvl_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && state == PVIC_REQ && core_ack |=> cpu_priority_level == $past(irq_level)
        && saved_level == $past(cpu_priority_level))
        else $error("accept did not load level");
endmodule // pvic_top

// ==== verif/pvic_core_model.sv ====
// core model answering interrupt requests and vector fetches
`timescale 1ns/1ps
module pvic_core_model
    import pvic_pkg::*;
(
    input wire logic aclk,
    input wire logic irq_request,
    input wire logic vec_fetch_req,
    input wire logic [PC_W-1:0] vec_fetch_addr,
    output logic core_ack,
    output logic prog_data_valid,
    output logic [PC_W-1:0] prog_data
);
    initial core_ack = 1'b0;
    initial prog_data_valid = 1'b0;
    initial prog_data = 24'h000000;
    // one-cycle ack, word returned a cycle after the fetch request
    always @(posedge aclk)
    begin
        core_ack <= irq_request && !core_ack;
        prog_data_valid <= vec_fetch_req && !prog_data_valid;
        // word on the program data bus, toggling once released
        prog_data <= (vec_fetch_req && !prog_data_valid) ? vec_fetch_addr ^ 24'h5a0000 : ~prog_data;
    end
endmodule // pvic_core_model

// ==== verif/test_pvic_top.sv ====
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
module test_pvic_top;
    import pvic_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
    logic [ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv, got_vec, got_pc;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [NUM_SRC-1:0] src_req = '0;
    logic [NUM_TRAPS-1:0] trap_req = '0;
    logic fetch_valid = 1'b0, jump_valid = 1'b0, instr_start = 1'b0, return_valid = 1'b0;
    logic [PC_W-1:0] fetch_addr = '0, jump_target = '0, prog_data, vec_fetch_addr, pc_load_value;
    logic [LVL_W-1:0] return_level = '0, irq_level, saved_level, cpu_priority_level;
    logic core_ack, prog_data_valid, irq_request, vec_fetch_req, pc_load;
    logic [VEC_W-1:0] irq_vector;
    logic [EXT_EDGE_W-1:0] ext_edge_select;
    int n_errors = 0, check_count = 0, hits = 0;
    pvic_top pvic_top_i (.*);
    pvic_core_model pvic_core_model_i (.*);
    initial forever #5 aclk = ~aclk;
    always @(posedge aclk)
    begin
        hits <= hits + int'(irq_request && core_ack);
        if (irq_request)
            got_vec <= {irq_level, 2'h0, irq_vector};
        if (pc_load)
            got_pc <= pc_load_value;
    end
    task stop_test;
        $display("errors=%0d checks=%0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task ck(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e)
        begin
            n_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic b;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        b = 1'b1;
        while (b)
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
            begin
                rr = s_axi_bresp;
                b = 1'b0;
            end
        end
    endtask
    task rd(input logic [7:0] a);
        logic b;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        b = 1'b1;
        while (b)
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
            begin
                rv = s_axi_rdata;
                rr = s_axi_rresp;
                b = 1'b0;
            end
        end
    endtask
    task pulse(input logic [NUM_SRC-1:0] r);
        src_req <= r;
        @(posedge aclk);
        src_req <= '0;
    endtask
    task go(input int n, input logic [31:0] v);
        int h;
        h = hits;
        instr_start <= 1'b1;
        @(posedge aclk);
        instr_start <= 1'b0;
        repeat (12) @(posedge aclk);
        ck(hits - h, n);
        if (n > 0)
            ck(got_vec, v);
    endtask
    initial
    begin
        #100000;
        n_errors++;
        stop_test;
    end
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        wr(8'h0c, 32'h0);
        ck(rr, RESP_OKAY);
        pulse(44'h1);
        rd(8'h00);
        ck(rv, 32'h1);
        wr(8'h00, 32'h0);
        rd(8'h00);
        ck(rv, 32'h0);
        wr(8'h20, 32'hffff);
        rd(8'h20);
        ck(rv, 32'h7777);
        wr(8'h4c, 32'hffff);
        rd(8'h4c);
        ck(rv & 32'hff00, 32'h0);
        rd(8'hfc);
        ck(rr, RESP_SLVERR);
        wr(8'h08, 32'hffff);
        rd(8'h08);
        ck(rv, 32'h1dff);
        wr(8'h08, 32'h0);
        wr(8'h20, 32'h5005);
        wr(8'h0c, 32'h2);
        pulse(44'h2);
        go(0, 0);
        wr(8'h00, 32'h0);
        wr(8'h0c, 32'h9);
        pulse(44'h9);
        go(1, 32'h508);
        ck(got_pc, 32'h5a0014);
        ck(cpu_priority_level, 32'h5);
        ck(saved_level, 32'h0);
        wr(8'h00, 32'h8);
        go(0, 0);
        wr(8'h50, 32'h8000);
        wr(8'h58, 32'h0);
        rd(8'h58);
        ck(rv, 32'h5);
        fetch_valid <= 1'b1;
        fetch_addr <= 24'h000010;
        jump_valid <= 1'b1;
        jump_target <= 24'h000030;
        @(posedge aclk);
        fetch_valid <= 1'b0;
        jump_valid <= 1'b0;
        rd(8'h50);
        ck(rv, 32'h8002);
        wr(8'h50, 32'h0);
        wr(8'h58, 32'h0);
        go(1, 32'h50b);
        wr(8'h58, 32'h0);
        wr(8'h54, 32'h801f);
        ck(ext_edge_select, 32'h1f);
        go(1, 32'h50b);
        ck(got_pc, 32'h5a009a);
        wr(8'h58, 32'h0);
        wr(8'h5c, 32'h3);
        go(0, 0);
        rd(8'h54);
        ck(rv, 32'hc01f);
        wr(8'h5c, 32'h0);
        wr(8'h50, 32'h8000);
        go(0, 0);
        wr(8'h50, 32'h0);
        ce <= 1'b0;
        src_req <= 44'h4;
        @(posedge aclk);
        ce <= 1'b1;
        src_req <= '0;
        rd(8'h00);
        ck(rv, 32'h8);
        trap_req <= 4'h1;
        @(posedge aclk);
        trap_req <= '0;
        go(1, 32'hb01);
        ck(cpu_priority_level, 32'hb);
        stop_test;
    end
endmodule // test_pvic_top
